// file: bpl_pkg.sv
/*
  Package for the battery protection state logic: fault codes, flag layout,
  timing constants and the carrier structs shared by the design files.
  Assumes analog comparators outside present clean fault levels.
*/
package bpl_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int unsigned CLK_HZ          = 40000000;
  localparam int unsigned MIN_DELAY_NS    = 100;     // Delay-test qualification time
  localparam int unsigned MIN_DELAY_CYC   =
    ((MIN_DELAY_NS * 40) + 999) / 1000;              // Rounded up at 40 cycles per us
  localparam int unsigned DLY_W           = 16;      // Width of delay settings
  localparam logic [15:0] DLY_RESET       = 16'h0000;

  // ************************************************************
  // Flag positions in the status vector
  // ************************************************************
  localparam int unsigned FLG_SHORT       = 0;
  localparam int unsigned FLG_OVERCUR     = 1;
  localparam int unsigned FLG_OVERVOLT    = 2;
  localparam int unsigned FLG_UNDERVOLT   = 3;
  localparam int unsigned FLG_TEMP        = 4;
  localparam int unsigned NUM_FLAGS       = 5;
  localparam logic [4:0]  FLAGS_RESET     = 5'h00;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic short_circuit;
    logic overcurrent;
    logic overvoltage;
    logic undervoltage;
    logic temperature;
  } bpl_fault_s;

  typedef struct packed {
    logic [15:0] short_dly;
    logic [15:0] overcur_dly;
    logic [15:0] overvolt_dly;
    logic [15:0] undervolt_dly;
  } bpl_delay_s;

  // Latch-clear sequence tracker, Gray coded from IDLE to ONE to ZERO; ZERO back to IDLE flips both bits
  typedef enum logic [1:0] {
    BPL_LC_IDLE = 2'b00,
    BPL_LC_ONE  = 2'b01,
    BPL_LC_ZERO = 2'b11
  } bpl_lc_e;

endpackage : bpl_pkg

// file: bpl_sync.sv
/*
  Two flip-flop synchroniser for a vector of asynchronous levels.
  Assumes inputs are slow levels; no multi-bit coherence is promised.
*/
`timescale 1ns/10ps
module bpl_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  // An empty vector has nothing to carry; refused at elaboration
  if (W < 1)
  begin : g_bad_width
    $error("bpl_sync: width must be at least one");
  end

  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] q_next;

  // ************************************************************
  // Next values: first stage only feeds the second
  // ************************************************************
  always_comb
  begin
    meta_next = d;
    q_next    = meta_reg;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg <= '0;
      q        <= '0;
    end
    else
    begin
      meta_reg <= meta_next;
      q        <= q_next;
    end
  end

endmodule : bpl_sync

// file: bpl_qual.sv
/*
  Fault qualification timer: asserts once the fault level has held for the
  programmed delay, or the short test delay when test is high.
  Assumes fault is already synchronised to clk.
*/
`timescale 1ns/10ps
module bpl_qual #(
  parameter int unsigned DW = bpl_pkg::DLY_W
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          fault,
  input  wire logic          test,
  input  wire logic [DW-1:0] delay,
  output logic               qual
);

  // Narrower counters cannot hold useful delays; refused at elaboration
  if (DW < 8)
  begin : g_bad_width
    $error("bpl_qual: delay width too small");
  end

  logic [DW-1:0] cnt_reg;
  logic [DW-1:0] cnt_next;
  logic [DW-1:0] limit;
  logic          qual_next;

  // ************************************************************
  // Counter restarts whenever the fault drops out early
  // ************************************************************
  always_comb
  begin
    limit     = test ? DW'(bpl_pkg::MIN_DELAY_CYC) : delay;
    cnt_next  = cnt_reg;
    qual_next = 1'b0;
    if (!fault)
      cnt_next = '0;
    else if (cnt_reg >= limit)
      qual_next = 1'b1;
    else
      cnt_next = cnt_reg + DW'(1);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_reg <= '0;
      qual    <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      qual    <= qual_next;
    end
  end

endmodule : bpl_qual

// file: bpl_prot.sv
/*
  Battery protection state logic: qualifies faults, keeps status flags that
  latch in host-control mode only, drives the alert and the charge and discharge
  switch controls in stand-alone and host-control modes.
  Assumes fault comparators are asynchronous levels and host commands are
  decoded elsewhere into levels and one-cycle pulses on this clock.
*/
`timescale 1ns/10ps
module bpl_prot (
  input  wire logic               MCLK,
  input  wire logic               RST_B,
  input  wire logic               HOST_MODE,       // 1 = host-control mode
  input  wire logic               SHORT_CIRCUIT_DET,
  input  wire logic               OVERCURRENT_DET,
  input  wire logic               OVERVOLTAGE_DET,
  input  wire logic               UNDERVOLTAGE_DET,
  input  wire logic               TEMP_BELOW_TRIP,  // Sense input below trip level
  input  wire logic               TEMP_ABOVE_RECOV, // Sense input above recovery level
  input  wire logic               PACK_AT_ZERO,     // Pack terminal at 0 V
  input  wire logic               DELAY_TEST_INPUT,
  input  wire bpl_pkg::bpl_delay_s DELAYS,
  input  wire logic               LATCH_CLEAR,
  input  wire logic               STATUS_READ,      // One-cycle pulse
  input  wire logic               UNDERVOLTAGE_SWITCH_DISABLE,
  input  wire logic               THERMISTOR_BIAS_EN,
  input  wire logic               HOST_CHARGE_ON,
  input  wire logic               HOST_DISCHARGE_ON,
  input  wire logic               SHUTDOWN_BIT,
  output bpl_pkg::bpl_fault_s     STATUS_FLAGS,
  output logic                    ALERT_N_OUT,
  output logic                    ALERT_N_OE,
  output logic                    CHARGE_SWITCH,
  output logic                    DISCHARGE_SWITCH,
  output logic                    THERMISTOR_BIAS,
  output logic                    SHUTDOWN
);

  // ************************************************************
  // Input synchronisation
  // ************************************************************
  localparam int unsigned NSYNC = 8;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] syn;
  logic             sc_s;
  logic             oc_s;
  logic             ov_s;
  logic             uv_s;
  logic             tlow_s;
  logic             thigh_s;
  logic             pz_s;
  logic             dt_s;

  assign raw_in = {SHORT_CIRCUIT_DET, OVERCURRENT_DET, OVERVOLTAGE_DET, UNDERVOLTAGE_DET,
                   TEMP_BELOW_TRIP, TEMP_ABOVE_RECOV, PACK_AT_ZERO, DELAY_TEST_INPUT};
  assign {sc_s, oc_s, ov_s, uv_s, tlow_s, thigh_s, pz_s, dt_s} = syn;

  // Comparator levels cross in from the analog side
  bpl_sync #(
    .W (NSYNC)
  ) u_sync (
    .clk   (MCLK),
    .rst_n (RST_B),
    .d     (raw_in),
    .q     (syn)
  );

  // ************************************************************
  // Qualification timers
  // ************************************************************
  logic [3:0]  fault_lvl;
  logic [3:0]  fault_q;
  logic [15:0] dly_sel [4];

  assign fault_lvl = {sc_s, oc_s, ov_s, uv_s};
  assign dly_sel[3] = DELAYS.short_dly;
  assign dly_sel[2] = DELAYS.overcur_dly;
  assign dly_sel[1] = DELAYS.overvolt_dly;
  assign dly_sel[0] = DELAYS.undervolt_dly;

  // One timer per delayed fault
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_qual
      bpl_qual #(
        .DW (bpl_pkg::DLY_W)
      ) u_qual (
        .clk   (MCLK),
        .rst_n (RST_B),
        .fault (fault_lvl[gi]),
        .test  (dt_s),
        .delay (dly_sel[gi]),
        .qual  (fault_q[gi])
      );
    end
  endgenerate

  // Temperature is always sensed in stand-alone mode, in host-control mode only while the bias is enabled
  logic temp_trip;
  logic temp_recov;
  assign temp_trip  = (THERMISTOR_BIAS_EN || !HOST_MODE) && tlow_s;
  assign temp_recov = (THERMISTOR_BIAS_EN || !HOST_MODE) && thigh_s;

  // ************************************************************
  // Latch-clear sequence tracker
  // ************************************************************
  bpl_pkg::bpl_lc_e lc_reg;
  bpl_pkg::bpl_lc_e lc_next;
  logic             lc_prev_reg;
  logic             lc_prev_next;
  logic             lc_release;    // Falling edge of latch clear

  always_comb
  begin
    lc_next      = lc_reg;
    lc_prev_next = LATCH_CLEAR;
    lc_release   = lc_prev_reg && !LATCH_CLEAR;
    case (lc_reg)
      bpl_pkg::BPL_LC_IDLE: if (LATCH_CLEAR) lc_next = bpl_pkg::BPL_LC_ONE;
      bpl_pkg::BPL_LC_ONE:  if (!LATCH_CLEAR) lc_next = bpl_pkg::BPL_LC_ZERO;
      bpl_pkg::BPL_LC_ZERO: if (STATUS_READ) lc_next = bpl_pkg::BPL_LC_IDLE;
                            else if (LATCH_CLEAR) lc_next = bpl_pkg::BPL_LC_ONE;
      default:              lc_next = bpl_pkg::BPL_LC_IDLE;
    endcase
  end

  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      lc_reg      <= bpl_pkg::BPL_LC_IDLE;
      lc_prev_reg <= 1'b0;
    end
    else
    begin
      lc_reg      <= lc_next;
      lc_prev_reg <= lc_prev_next;
    end
  end

  // ************************************************************
  // Flags, alert and switches
  // ************************************************************
  logic [4:0]  active;          // Qualified conditions, flag order
  logic [4:0]  flags_reg;
  logic [4:0]  flags_next;
  logic [4:0]  lc_armed_reg;    // Latch released since fault went away
  logic [4:0]  lc_armed_next;
  logic        alert_reg;
  logic        alert_next;
  logic        temp_hold_reg;
  logic        temp_hold_next;
  logic        chg_reg;
  logic        chg_next;
  logic        dsg_reg;
  logic        dsg_next;
  logic        shd_reg;
  logic        shd_next;
  logic        bias_reg;
  logic        ack_read;

  // Temperature stays tripped until the recovery level is seen
  always_comb
  begin
    temp_hold_next = temp_hold_reg;
    if (temp_trip)
      temp_hold_next = 1'b1;
    else if (temp_recov)
      temp_hold_next = 1'b0;
  end

  always_comb
  begin
    active[bpl_pkg::FLG_SHORT]     = fault_q[3];
    active[bpl_pkg::FLG_OVERCUR]   = fault_q[2];
    active[bpl_pkg::FLG_OVERVOLT]  = fault_q[1];
    active[bpl_pkg::FLG_UNDERVOLT] = fault_q[0];
    active[bpl_pkg::FLG_TEMP]      = temp_hold_reg;
  end

  // Flag update: a new fault always wins over a clear in the same cycle
  always_comb
  begin
    flags_next    = flags_reg;
    lc_armed_next = lc_armed_reg;
    alert_next    = alert_reg;
    ack_read      = STATUS_READ && (lc_reg == bpl_pkg::BPL_LC_ZERO);
    if (!HOST_MODE)
    begin
      // Stand-alone: flags follow the qualified conditions
      flags_next    = active;
      lc_armed_next = '0;
      alert_next    = ~|active;
    end
    else
    begin
      for (int i = 0; i < bpl_pkg::NUM_FLAGS; i++)
      begin
        if (active[i])
          lc_armed_next[i] = 1'b0;
        else if (lc_release && flags_reg[i])
          lc_armed_next[i] = 1'b1;
        if (ack_read && lc_armed_reg[i] && !active[i])
        begin
          flags_next[i]    = 1'b0;
          lc_armed_next[i] = 1'b0;
        end
        if (active[i])
          flags_next[i] = 1'b1;
      end
      if (|(active & ~flags_reg))
        alert_next = 1'b0;
      else if (ack_read && !(|flags_next))
        alert_next = 1'b1;
    end
  end

  // Switch control per mode
  always_comb
  begin
    chg_next = chg_reg;
    dsg_next = dsg_reg;
    shd_next = shd_reg;
    if (!HOST_MODE)
    begin
      chg_next = !(active[bpl_pkg::FLG_SHORT] || active[bpl_pkg::FLG_OVERCUR]
                   || active[bpl_pkg::FLG_OVERVOLT] || active[bpl_pkg::FLG_TEMP]);
      dsg_next = !(active[bpl_pkg::FLG_SHORT] || active[bpl_pkg::FLG_OVERCUR]
                   || active[bpl_pkg::FLG_UNDERVOLT] || active[bpl_pkg::FLG_TEMP]);
      if (active[bpl_pkg::FLG_UNDERVOLT] && pz_s)
        shd_next = 1'b1;
    end
    else
    begin
      // Host commands are obeyed only while no fault forces the switch off
      chg_next = HOST_CHARGE_ON && !(flags_next[bpl_pkg::FLG_SHORT]
                 || flags_next[bpl_pkg::FLG_OVERCUR] || flags_next[bpl_pkg::FLG_OVERVOLT]
                 || flags_next[bpl_pkg::FLG_TEMP]);
      dsg_next = HOST_DISCHARGE_ON && !(flags_next[bpl_pkg::FLG_SHORT]
                 || flags_next[bpl_pkg::FLG_OVERCUR] || flags_next[bpl_pkg::FLG_TEMP]
                 || (flags_next[bpl_pkg::FLG_UNDERVOLT]
                     && !UNDERVOLTAGE_SWITCH_DISABLE));
      // Shutdown once asked; host is trusted to have drained the pack
      if (SHUTDOWN_BIT)
        shd_next = 1'b1;
    end
    if (shd_next)
    begin
      chg_next = 1'b0;
      dsg_next = 1'b0;
    end
  end

  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      flags_reg     <= bpl_pkg::FLAGS_RESET;
      lc_armed_reg  <= '0;
      alert_reg     <= 1'b1;
      temp_hold_reg <= 1'b0;
      chg_reg       <= 1'b0;
      dsg_reg       <= 1'b0;
      shd_reg       <= 1'b0;
      bias_reg      <= 1'b0;
    end
    else
    begin
      flags_reg     <= flags_next;
      lc_armed_reg  <= lc_armed_next;
      alert_reg     <= alert_next;
      temp_hold_reg <= temp_hold_next;
      chg_reg       <= chg_next;
      dsg_reg       <= dsg_next;
      shd_reg       <= shd_next;
      bias_reg      <= THERMISTOR_BIAS_EN;
    end
  end

  // ************************************************************
  // Outputs, all from flip-flops except ALERT_N_OUT, which is tied low
  // ************************************************************
  // One driver for the whole carrier, fields in struct order
  assign STATUS_FLAGS     = {flags_reg[bpl_pkg::FLG_SHORT],
                             flags_reg[bpl_pkg::FLG_OVERCUR],
                             flags_reg[bpl_pkg::FLG_OVERVOLT],
                             flags_reg[bpl_pkg::FLG_UNDERVOLT],
                             flags_reg[bpl_pkg::FLG_TEMP]};
  assign ALERT_N_OUT      = 1'b0;          // Open drain: only ever pulls low
  assign ALERT_N_OE       = ~alert_reg;
  assign CHARGE_SWITCH    = chg_reg;
  assign DISCHARGE_SWITCH = dsg_reg;
  assign THERMISTOR_BIAS  = bias_reg;
  assign SHUTDOWN         = shd_reg;

endmodule : bpl_prot

// file: bpl_prot_checker.sv
/*
  Checker for the protection state logic, bound to bpl_prot.
  Assumes one clock, MCLK, and RST_B as its asynchronous reset.
*/
`timescale 1ns/10ps
module bpl_prot_checker (
  input wire logic                MCLK,
  input wire logic                RST_B,
  input wire logic                HOST_MODE,
  input wire logic                OVERVOLTAGE_DET,
  input wire logic                DELAY_TEST_INPUT,
  input wire logic                STATUS_READ,
  input wire logic                UNDERVOLTAGE_SWITCH_DISABLE,
  input wire bpl_pkg::bpl_fault_s STATUS_FLAGS,
  input wire logic                ALERT_N_OE,
  input wire logic                CHARGE_SWITCH,
  input wire logic                DISCHARGE_SWITCH
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_B);

  // ************************************************************
  // Sequences
  // ************************************************************
  // Fault held long enough for the shortened qualification
  sequence ov_held;
    (DELAY_TEST_INPUT && OVERVOLTAGE_DET) [*8];
  endsequence
  // Host acknowledged status one or two cycles back
  sequence read_seen;
    $past(STATUS_READ) || $past(STATUS_READ, 2);
  endsequence

  // ************************************************************
  // Properties
  // ************************************************************
  chk_flag_alert: assert property (
    (STATUS_FLAGS & ~$past(STATUS_FLAGS)) != 5'h00 |-> ##[0:1] ALERT_N_OE)
    else $error("alert missing on new flag");
  chk_current_both_off: assert property (
    $rose(STATUS_FLAGS.short_circuit || STATUS_FLAGS.overcurrent)
    |=> !CHARGE_SWITCH && !DISCHARGE_SWITCH)
    else $error("switch on during current fault");
  chk_ov_charge_off: assert property (
    $rose(STATUS_FLAGS.overvoltage) |=> !CHARGE_SWITCH)
    else $error("charge on during overvoltage");
  chk_temp_both_off: assert property (
    $rose(STATUS_FLAGS.temperature) |=> !CHARGE_SWITCH && !DISCHARGE_SWITCH)
    else $error("switch on during overtemperature");
  chk_uv_dsg_off: assert property (
    $rose(STATUS_FLAGS.undervoltage) && (!HOST_MODE || !UNDERVOLTAGE_SWITCH_DISABLE)
    |=> !DISCHARGE_SWITCH)
    else $error("discharge on during undervoltage");
  chk_uv_dsg_kept: assert property (
    HOST_MODE && UNDERVOLTAGE_SWITCH_DISABLE && $rose(STATUS_FLAGS.undervoltage)
    && $past(DISCHARGE_SWITCH) |-> DISCHARGE_SWITCH ##1 DISCHARGE_SWITCH)
    else $error("discharge touched with switch disable set");
  chk_flags_latched: assert property (
    HOST_MODE && $fell(STATUS_FLAGS != 5'h00) |-> read_seen)
    else $error("flags cleared without status read");
  chk_alert_release: assert property (
    HOST_MODE && $fell(ALERT_N_OE) |-> read_seen)
    else $error("alert released without status read");
  chk_test_delay: assert property (
    ov_held |-> ##[0:4] STATUS_FLAGS.overvoltage)
    else $error("test delay not minimal");
endmodule : bpl_prot_checker

bind bpl_prot bpl_prot_checker bpl_prot_checker_inst (
  .MCLK(MCLK), .RST_B(RST_B), .HOST_MODE(HOST_MODE), .OVERVOLTAGE_DET(OVERVOLTAGE_DET),
  .DELAY_TEST_INPUT(DELAY_TEST_INPUT), .STATUS_READ(STATUS_READ),
  .UNDERVOLTAGE_SWITCH_DISABLE(UNDERVOLTAGE_SWITCH_DISABLE), .STATUS_FLAGS(STATUS_FLAGS),
  .ALERT_N_OE(ALERT_N_OE), .CHARGE_SWITCH(CHARGE_SWITCH), .DISCHARGE_SWITCH(DISCHARGE_SWITCH)
);

// file: bpl_host_model.sv
/*
  Behavioural host controller issuing protection recovery commands.
  Assumes commands are decoded to levels and pulses on MCLK.
*/
`timescale 1ns/10ps
module bpl_host_model (
  input  wire logic MCLK,
  output logic      LATCH_CLEAR,
  output logic      STATUS_READ,
  output logic      HOST_CHARGE_ON,
  output logic      HOST_DISCHARGE_ON,
  output logic      THERMISTOR_BIAS_EN,
  output logic      SHUTDOWN_BIT
);
  // Idle host: everything off, never shuts down
  initial
  begin
    LATCH_CLEAR = 1'b0;
    STATUS_READ = 1'b0;
    HOST_CHARGE_ON = 1'b0;
    HOST_DISCHARGE_ON = 1'b0;
    THERMISTOR_BIAS_EN = 1'b0;
    SHUTDOWN_BIT = 1'b0;
  end

  // Levels change only just after a falling edge
  task automatic switches(input logic charge_switch, input logic discharge_switch);
    @(negedge MCLK);
    THERMISTOR_BIAS_EN = 1'b1;
    HOST_CHARGE_ON = charge_switch;
    HOST_DISCHARGE_ON = discharge_switch;
  endtask : switches

  // One-cycle acknowledging read
  task automatic read_status;
    @(negedge MCLK);
    STATUS_READ = 1'b1;
    @(negedge MCLK);
    STATUS_READ = 1'b0;
  endtask : read_status

  // Gap models a slow host; latch clear idles low so 0-1-0 and 1-0 coincide
  task automatic recover(input logic charge_switch, input logic discharge_switch, input logic rd_first, input int gap);
    @(negedge MCLK);
    LATCH_CLEAR = 1'b1;
    repeat (gap) @(negedge MCLK);
    LATCH_CLEAR = 1'b0;
    repeat (gap) @(negedge MCLK);
    if (rd_first) read_status();
    switches(HOST_CHARGE_ON | charge_switch, HOST_DISCHARGE_ON | discharge_switch);
    repeat (gap) @(negedge MCLK);
    if (!rd_first) read_status();
  endtask : recover

  // Drain first: discharge off, bench holds the pack at 0 V, then the bit
  task automatic shut_down(input int gap);
    @(negedge MCLK);
    HOST_DISCHARGE_ON = 1'b0;
    repeat (gap) @(negedge MCLK);
    SHUTDOWN_BIT = 1'b1;
  endtask : shut_down
endmodule : bpl_host_model

// file: bpl_prot_bench.sv
/*
  Self-checking bench for bpl_prot: stand-alone table, host recovery, shutdown.
  Assumes the checker is bound and the host model drives host commands.
*/
`timescale 1ns/10ps
module bpl_prot_bench;
  logic                mclk, rst_b, host_mode, pack_zero, dtest, uvsd;
  logic                lc, rd, hchg, hdsg, bias_en, sdb;
  logic                alert_oe, alert_out, bias, charge_switch, discharge_switch, shdn;
  logic [4:0]          det;
  logic [8:0]          obs;
  logic [17:0]         nt;
  logic [15:0]         dly;
  bpl_pkg::bpl_fault_s flags;
  bpl_pkg::bpl_delay_s delays;
  logic [17:0]         notes[$];
  int                  seed, miscompares, compares, cycles, i;
  event                take;

  bpl_prot bpl_prot_inst (
    .MCLK(mclk), .RST_B(rst_b), .HOST_MODE(host_mode), .SHORT_CIRCUIT_DET(det[4]),
    .OVERCURRENT_DET(det[3]), .OVERVOLTAGE_DET(det[2]), .UNDERVOLTAGE_DET(det[1]),
    .TEMP_BELOW_TRIP(det[0]), .TEMP_ABOVE_RECOV(~det[0]), .PACK_AT_ZERO(pack_zero),
    .DELAY_TEST_INPUT(dtest), .DELAYS(delays), .LATCH_CLEAR(lc), .STATUS_READ(rd),
    .UNDERVOLTAGE_SWITCH_DISABLE(uvsd), .THERMISTOR_BIAS_EN(bias_en), .HOST_CHARGE_ON(hchg),
    .HOST_DISCHARGE_ON(hdsg), .SHUTDOWN_BIT(sdb), .STATUS_FLAGS(flags),
    .ALERT_N_OUT(alert_out), .ALERT_N_OE(alert_oe), .CHARGE_SWITCH(charge_switch),
    .DISCHARGE_SWITCH(discharge_switch), .THERMISTOR_BIAS(bias), .SHUTDOWN(shdn)
  );
  bpl_host_model bpl_host_model_inst (
    .MCLK(mclk), .LATCH_CLEAR(lc), .STATUS_READ(rd), .HOST_CHARGE_ON(hchg),
    .HOST_DISCHARGE_ON(hdsg), .THERMISTOR_BIAS_EN(bias_en), .SHUTDOWN_BIT(sdb)
  );
  assign obs = {shdn, flags, alert_oe, charge_switch, discharge_switch};

  // ************************************************************
  // Checking and reporting
  // ************************************************************
  task automatic check(input logic [8:0] seen, input logic [8:0] want);
    compares++;
    if (seen !== want)
    begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  // Note an expectation, let outputs settle (bounded), then hand it over
  task automatic note(input logic [8:0] mask, input logic [8:0] want, input bit wait_en);
    int n;
    n = 0;
    notes.push_back({mask, want & mask});
    while (wait_en && n < 80 && (obs & mask) !== (want & mask))
    begin
      @(negedge mclk);
      n++;
    end
    -> take;
    @(negedge mclk);
  endtask : note

  // Flag alone, alert asserted, switches per fault kind
  function automatic logic [8:0] pattern(input int k, input logic keep);
    pattern = {1'b0, 5'h10 >> k, 1'b1, k == 3, k == 2 || keep};
  endfunction : pattern

  // Monitor takes the oldest note whenever a result is presented
  always @(take)
  begin
    nt = notes.pop_front();
    check(obs & nt[17:9], nt[8:0]);
  end

  // Hang guard
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      tally_and_finish();
    end
  end

  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // ************************************************************
  // Stimulus
  // ************************************************************
  initial
  begin
    seed = 41304;
    rst_b = 1'b0;
    host_mode = 1'b0;
    det = 5'h00;
    pack_zero = 1'b0;
    dtest = 1'b1;
    uvsd = 1'b0;
    delays = {4{16'hffff}};
    repeat (2) @(negedge mclk);
    note(9'h1ff, 9'h000, 0);
    rst_b = 1'b1;
    note(9'h1ff, 9'h003, 1);
    det = 5'h04;
    note(9'h1ff, 9'h025, 1);
    det = 5'h00;
    note(9'h1ff, 9'h003, 1);
    $display("test done: delay test input");
    // Broken faults shorter than the delay must never qualify
    dtest = 1'b0;
    dly = 16'd20 + 16'($random(seed) & 15);
    delays = {4{dly}};
    repeat (2)
    begin
      det = 5'h04;
      repeat (dly - 4) @(negedge mclk);
      det = 5'h00;
      @(negedge mclk);
    end
    repeat (dly + 8) @(negedge mclk);
    note(9'h1ff, 9'h003, 0);
    $display("test done: qualification restart");
    for (i = 0; i < 5; i++)
    begin
      det = 5'h10 >> i;
      note(9'h1ff, pattern(i, 1'b0), 1);
      det = 5'h00;
      note(9'h1ff, 9'h003, 1);
    end
    $display("test done: stand-alone table");
    host_mode = 1'b1;
    bpl_host_model_inst.switches(1'b1, 1'b1);
    note(9'h1ff, 9'h003, 1);
    // Bias follows its enable; the open-drain data pin only ever pulls low
    check({7'h00, bias, alert_out}, 9'h002);
    for (int k = 0; k < 6; k++)
    begin
      i = (k == 5) ? 3 : k;
      uvsd = (k == 5);
      det = 5'h10 >> i;
      note(9'h1ff, pattern(i, uvsd), 1);
      if (uvsd)
        bpl_host_model_inst.switches(1'b1, 1'b0);
      det = 5'h00;
      repeat (10) @(negedge mclk);
      note(9'h1ff, pattern(i, 1'b0), 0);
      bpl_host_model_inst.recover(i != 3, i != 2, i < 3, 1 + ($random(seed) & 3));
      note(9'h1ff, 9'h003, 1);
    end
    $display("test done: host recovery");
    host_mode = 1'b0;
    uvsd = 1'b0;
    note(9'h1ff, 9'h003, 1);
    pack_zero = 1'b1;
    det = 5'h02;
    note(9'h103, 9'h100, 1);
    // Shutdown is sticky, so a mid-run reset clears it before the host path
    det = 5'h00;
    rst_b = 1'b0;
    host_mode = 1'b1;
    repeat (3) @(negedge mclk);
    note(9'h1ff, 9'h000, 0);
    rst_b = 1'b1;
    note(9'h1ff, 9'h003, 1);
    bpl_host_model_inst.shut_down(1 + ($random(seed) & 3));
    note(9'h103, 9'h100, 1);
    $display("test done: shutdown");
    tally_and_finish();
  end
endmodule : bpl_prot_bench
